// ### bench/ipwc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipwc_cpu_model (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic irq_req, // Offered request
    input wire logic [15:0] irq_vector, // Offered vector
    input wire logic auto_ack, // Ack at once
    input wire logic ret_go, // Return request
    output logic irq_ack, // Vector taken
    output logic irq_return // Routine returned
);
    logic [15:0] last_vec;
    int acks;
    int depth;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            last_vec <= 16'h0000;
            acks <= 0;
            depth <= 0;
        end else begin
            irq_ack <= auto_ack && irq_req && !irq_ack;
            irq_return <= ret_go && depth > 0;
            if (irq_ack && irq_req) begin
                last_vec <= irq_vector;
                acks <= acks + 1;
            end
            // Routines entered, not yet returned
            depth <= depth + 32'(irq_ack && irq_req) - 32'(ret_go && depth > 0);
        end
    end
endmodule : ipwc_cpu_model
`default_nettype wire

// ### bench/ipwc_props.sv
`timescale 1ns/1ps
`default_nettype none
module ipwc_props
    import ipwc_pkg::*;
#(
    parameter int P0_WIDTH = 6,
    parameter int WAKE_CYCLES = 8,
    parameter int OSC_STARTUP_CYCLES = 4
) (
    input wire logic REF_CLK, // Clock
    input wire logic NRST, // Reset
    input wire logic PSEL, // Select
    input wire logic PENABLE, // Access
    input wire logic PWRITE, // Write
    input wire logic PREADY, // Ready
    input wire logic [ADDR_W-1:0] PADDR, // Address
    input wire logic [DATA_W-1:0] PWDATA, // Write data
    input wire logic IRQ_REQ, // Request
    input wire logic IRQ_ACK, // Acknowledge
    input wire logic [P0_WIDTH-1:0] P0_IN, // Port pins
    input wire logic TIMER_A_RUN, // Timer A run
    input wire logic WDT_OPTION_EN, // WDT option
    input wire logic WDT_ALWAYS_ON, // WDT in stop
    input wire logic FAST_OSC_EN, // Fast osc
    input wire logic SLOW_OSC_EN, // Slow osc
    input wire logic CPU_RUN, // CPU runs
    input wire logic TIMER_A_CLK_EN, // Timer A clock
    input wire logic WDT_RUN, // Watchdog runs
    input wire logic IRQ_LOGIC_EN, // IRQ logic
    input wire logic [1:0] POWER_MODE // Mode
);
    logic pwr_wr;
    logic [15:0] wake_cnt_reg;
    assign pwr_wr = PSEL && PENABLE && PWRITE && PREADY && PADDR == OFS_POWER;
    // Cycles spent in the stop-exit wait
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            wake_cnt_reg <= 16'h0000;
        end else begin
            wake_cnt_reg <= (POWER_MODE == 2'h3) ? wake_cnt_reg + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    chk_reset_normal: assert property ($past(!NRST) |-> POWER_MODE == 2'h0 && CPU_RUN)
        else $error("reset mode");
    chk_stop_entry: assert property (pwr_wr && POWER_MODE == 2'h0 && PWDATA[1]
        |-> ##[1:2] POWER_MODE == 2'h2) else $error("no stop");
    chk_idle_entry: assert property (pwr_wr && POWER_MODE == 2'h0 && PWDATA[1:0] == 2'h1
        |-> ##[1:2] POWER_MODE == 2'h1) else $error("no idle");
    chk_stop_halt: assert property (POWER_MODE == 2'h2 && $past(POWER_MODE) == 2'h2
        |-> !CPU_RUN && !FAST_OSC_EN && !IRQ_LOGIC_EN && SLOW_OSC_EN == $past(WDT_ALWAYS_ON))
        else $error("stop gating");
    chk_idle_keep: assert property (POWER_MODE == 2'h1 && $past(POWER_MODE) == 2'h1
        |-> !CPU_RUN && FAST_OSC_EN && TIMER_A_CLK_EN == $past(TIMER_A_RUN))
        else $error("idle gating");
    chk_wdt_option: assert property ($past(NRST) |-> WDT_RUN == $past(WDT_OPTION_EN))
        else $error("watchdog run");
    chk_stop_hold: assert property (POWER_MODE == 2'h2 |=> POWER_MODE inside {2'h2, 2'h3})
        else $error("stop left");
    chk_pin_wake: assert property (POWER_MODE == 2'h2 && $past(POWER_MODE) == 2'h2
        && P0_IN != $past(P0_IN) |-> ##[1:3] POWER_MODE == 2'h3) else $error("no pin wake");
    chk_wake_time: assert property (POWER_MODE == 2'h0 && $past(POWER_MODE) == 2'h3
        |-> wake_cnt_reg == 16'(WAKE_CYCLES + OSC_STARTUP_CYCLES)) else $error("wake length");
    chk_req_stands: assert property (IRQ_REQ && !IRQ_ACK |=> IRQ_REQ)
        else $error("request dropped");
    chk_ack_clears: assert property (IRQ_REQ && IRQ_ACK |=> !IRQ_REQ)
        else $error("request held");
endmodule : ipwc_props
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ipwc_pkg::*;
;
    localparam int WAKE_CYCLES = 8;
    localparam int OSC_STARTUP_CYCLES = 4;
    typedef struct packed {logic [8:0] ev; logic [15:0] vec; logic [8:0] flags;} ipwc_row_t;
    ipwc_row_t rows [9] = '{'{9'h001, 16'h0003, 9'h000}, '{9'h002, 16'h0083, 9'h000},
        '{9'h004, 16'h000B, 9'h000}, '{9'h008, 16'h008B, 9'h000},
        '{9'h010, 16'h0013, 9'h000}, '{9'h020, 16'h001B, 9'h000},
        '{9'h040, 16'h0023, 9'h040}, '{9'h080, 16'h0023, 9'h080},
        '{9'h100, 16'h00EB, 9'h000}};
    logic REF_CLK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rdata;
    logic PREADY, PSLVERR, IRQ_ACK, IRQ_RETURN, IRQ_REQ, rerr;
    logic [8:0] SRC_EVENT = 9'h000;
    logic [15:0] IRQ_VECTOR;
    logic [1:0] IRQ_LEVEL, POWER_MODE;
    logic [5:0] P0_IN = 6'h2A;
    logic TIMER_A_RUN = 1'b1, TIMER_B_RUN = 1'b0, TIMER_C_ENABLE = 1'b1, SERIAL_ENABLE = 1'b1;
    logic CONV_ENABLE = 1'b0, WDT_OPTION_EN = 1'b1, WDT_ALWAYS_ON = 1'b0;
    logic auto_ack = 1'b1, ret_go = 1'b0;
    logic FAST_OSC_EN, SLOW_OSC_EN, CPU_RUN, TIMER_A_CLK_EN, TIMER_B_CLK_EN, TIMER_C_CLK_EN;
    logic SERIAL_CLK_EN, CONV_CLK_EN, WDT_RUN, IRQ_LOGIC_EN;
    int bad_count = 0;
    int checks_done = 0;
    int n0;

    ipwc_ctrl #(.WAKE_CYCLES(WAKE_CYCLES), .OSC_STARTUP_CYCLES(OSC_STARTUP_CYCLES)) DUT (
        .REF_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .SRC_EVENT, .IRQ_ACK, .IRQ_RETURN, .IRQ_REQ, .IRQ_VECTOR, .IRQ_LEVEL,
        .P0_IN, .TIMER_A_RUN, .TIMER_B_RUN, .TIMER_C_ENABLE, .SERIAL_ENABLE, .CONV_ENABLE,
        .WDT_OPTION_EN, .WDT_ALWAYS_ON, .FAST_OSC_EN, .SLOW_OSC_EN, .CPU_RUN, .TIMER_A_CLK_EN,
        .TIMER_B_CLK_EN, .TIMER_C_CLK_EN, .SERIAL_CLK_EN, .CONV_CLK_EN, .WDT_RUN,
        .IRQ_LOGIC_EN, .POWER_MODE);

    ipwc_cpu_model m_cpu (.clk(REF_CLK), .nrst(NRST), .irq_req(IRQ_REQ), .irq_vector(IRQ_VECTOR),
        .auto_ack(auto_ack), .ret_go(ret_go), .irq_ack(IRQ_ACK), .irq_return(IRQ_RETURN));

    initial begin
        forever #12.5 REF_CLK = ~REF_CLK;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rdata = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, name);
    endtask : rd

    task automatic pulse(input logic [8:0] m);
        @(posedge REF_CLK);
        SRC_EVENT <= m;
        @(posedge REF_CLK);
        SRC_EVENT <= 9'h000;
    endtask : pulse

    task automatic ret;
        @(posedge REF_CLK);
        ret_go <= 1'b1;
        @(posedge REF_CLK);
        ret_go <= 1'b0;
        repeat (4) @(posedge REF_CLK);
    endtask : ret

    task automatic wait_mode(input logic [1:0] m);
        int n = 0;
        while (POWER_MODE !== m && n < 200) begin
            @(posedge REF_CLK);
            n++;
        end
        chk(32'(POWER_MODE), 32'(m), "power_mode");
    endtask : wait_mode

    task automatic wait_ack(input int want);
        int n = 0;
        while (m_cpu.acks != want && n < 200) begin
            @(posedge REF_CLK);
            n++;
        end
        chk(32'(m_cpu.acks), 32'(want), "ack_count");
    endtask : wait_ack

    initial begin
        repeat (20000) @(posedge REF_CLK);
        bad_count++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge REF_CLK);
        NRST <= 1'b1;
        chk(32'(CPU_RUN), 32'h1, "cpu_run");
        rd(OFS_ENABLE, 32'h0, "enable_rst");
        rd(OFS_LEVEL, 32'h0, "level_rst");
        rd(8'h20, 32'h0, "unmapped");
        chk(32'(rerr), 32'h1, "slverr");
        $display("reset test done");
        apb(1'b1, OFS_ENABLE, 32'h1FF);
        foreach (rows[i]) begin
            pulse(rows[i].ev);
            wait_ack(i + 1);
            chk(32'(m_cpu.last_vec), 32'(rows[i].vec), "vector");
            rd(OFS_FLAGS, 32'(rows[i].flags), "flags_after");
            apb(1'b1, OFS_FLAGS, 32'h1FF);
            ret();
        end
        $display("vector test done");
        apb(1'b1, OFS_ENABLE, 32'h0FF);
        pulse(9'h004);
        repeat (4) @(posedge REF_CLK);
        chk(32'(IRQ_REQ), 32'h0, "no_global");
        rd(OFS_FLAGS, 32'h004, "flag_unenabled");
        apb(1'b1, OFS_ENABLE, 32'h1FB);
        repeat (4) @(posedge REF_CLK);
        chk(32'(IRQ_REQ), 32'h0, "no_source_en");
        apb(1'b1, OFS_FLAGS, 32'h1FF);
        $display("gating test done");
        apb(1'b1, OFS_ENABLE, 32'h1FF);
        apb(1'b1, OFS_LEVEL, 32'h2024);
        n0 = m_cpu.acks;
        pulse(9'h011);
        wait_ack(n0 + 1);
        chk(32'(m_cpu.last_vec), 32'h0013, "level_wins");
        pulse(9'h004);
        repeat (6) @(posedge REF_CLK);
        chk(32'(m_cpu.acks), 32'(n0 + 1), "lower_pends");
        pulse(9'h100);
        wait_ack(n0 + 2);
        chk(32'(m_cpu.last_vec), 32'h00EB, "preempt");
        ret();
        chk(32'(m_cpu.acks), 32'(n0 + 2), "still_pending");
        ret();
        wait_ack(n0 + 3);
        chk(32'(m_cpu.last_vec), 32'h0003, "natural_tie");
        repeat (6) @(posedge REF_CLK);
        chk(32'(m_cpu.acks), 32'(n0 + 3), "equal_waits");
        ret();
        wait_ack(n0 + 4);
        chk(32'(m_cpu.last_vec), 32'h000B, "after_return");
        ret();
        apb(1'b1, OFS_LEVEL, 32'h0);
        $display("priority test done");
        for (int i = 0; i < 3; i++) begin
            WDT_ALWAYS_ON <= 1'(i == 1);
            WDT_OPTION_EN <= 1'(i != 1);
            apb(1'b1, OFS_POWER, 32'(i + 1));
            wait_mode((i == 0) ? 2'h1 : 2'h2);
            repeat (3) @(posedge REF_CLK);
            chk(32'(CPU_RUN), 32'h0, "cpu_halt");
            chk(32'(FAST_OSC_EN), 32'(i == 0), "fast_osc");
            chk(32'(SLOW_OSC_EN), 32'(i < 2), "slow_osc");
            chk(32'(TIMER_A_CLK_EN), 32'(i == 0), "timer_a_clk");
            chk(32'(WDT_RUN), 32'(i != 1), "wdt_run");
            chk(32'({TIMER_B_CLK_EN, TIMER_C_CLK_EN, SERIAL_CLK_EN, CONV_CLK_EN}),
                32'(i ? 0 : 6), "clk_ens");
            if (i > 0) begin
                pulse(9'h020);
                chk(32'(POWER_MODE), 32'h2, "irq_no_wake");
            end
            P0_IN <= P0_IN ^ (6'h01 << i);
            wait_mode(2'h0);
            rd(OFS_POWER, 32'h0, "power_cleared");
            rd(OFS_FLAGS, 32'h0, "no_flag_in_stop");
        end
        WDT_OPTION_EN <= 1'b1;
        $display("power mode test done");
        apb(1'b1, OFS_POWER, 32'h1);
        wait_mode(2'h1);
        n0 = m_cpu.acks;
        auto_ack <= 1'b0;
        pulse(9'h020);
        wait_mode(2'h0);
        repeat (8) @(posedge REF_CLK);
        chk(32'(IRQ_REQ), 32'h1, "req_waits");
        chk(32'(IRQ_VECTOR), 32'h001B, "wake_vector");
        chk(32'(IRQ_LEVEL), 32'h0, "wake_level");
        auto_ack <= 1'b1;
        wait_ack(n0 + 1);
        ret();
        $display("idle wake test done");
        finish_test();
    end
endmodule : tb_top

bind ipwc_ctrl ipwc_props #(.P0_WIDTH(P0_WIDTH), .WAKE_CYCLES(WAKE_CYCLES),
    .OSC_STARTUP_CYCLES(OSC_STARTUP_CYCLES)) u_props (.REF_CLK, .NRST, .PSEL, .PENABLE,
    .PWRITE, .PREADY, .PADDR, .PWDATA, .IRQ_REQ, .IRQ_ACK, .P0_IN, .TIMER_A_RUN,
    .WDT_OPTION_EN, .WDT_ALWAYS_ON, .FAST_OSC_EN, .SLOW_OSC_EN, .CPU_RUN, .TIMER_A_CLK_EN,
    .WDT_RUN, .IRQ_LOGIC_EN, .POWER_MODE);
`default_nettype wire

// ### src/ipwc_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module ipwc_arbiter
    import ipwc_pkg::*;
(
    input wire logic [SRC_N-1:0] req, // Enabled pending sources
    input wire logic [GROUP_N-1:0] lvl_low, // Group level low bits
    input wire logic [GROUP_N-1:0] lvl_high, // Group level high bits
    output logic valid, // Some source wins
    output logic [IDX_W-1:0] idx, // Winning source
    output logic [LEVEL_W-1:0] level // Winner's level
);

    // Highest index first; >= lets the lower index win ties
    always_comb begin
        logic [LEVEL_W-1:0] l;
        l = '0;
        valid = 1'b0;
        idx = '0;
        level = '0;
        for (int i = SRC_N - 1; i >= 0; i--) begin
            l = {lvl_high[GROUP_OF[i]], lvl_low[GROUP_OF[i]]};
            if (req[i] && (!valid || l >= level)) begin
                valid = 1'b1;
                idx = IDX_W'(i);
                level = l;
            end
        end
    end

endmodule : ipwc_arbiter
`default_nettype wire

// ### src/ipwc_ctrl.sv
// How it works
// - STOP halts fast clock, CPU, peripherals
// - IDLE halts only the CPU
// - Stop bit enters STOP; cleared at wake
// - Idle bit enters IDLE; cleared at wake
// - STOP exits only on pin change
// - IDLE exits on pin change or interrupt
// - Either pin edge wakes
// - Interrupt wake sets its flag
// - STOP exit waits settle time
// - Reset starts in normal mode
// - Watchdog follows option only
// - Events set flags in NORMAL and IDLE only
// - Needs source and global enable
// - Fixed vector per source
// - Natural order breaks ties
// - Vectoring clears non-serial flag
// - Equal level waits for return
// - Two bits per group give level
// - Sources map to six groups
// - Group shares one level
// - Level, then group, then source
// - Higher level preempts lower
// - Idle is bit 0, stop bit 1
`timescale 1ns/1ps
`default_nettype none
module ipwc_ctrl
    import ipwc_pkg::*;
#(
    parameter int P0_WIDTH = 6,
    parameter int WAKE_CYCLES = WAKE_CYCLES_DEF,
    parameter int OSC_STARTUP_CYCLES = OSC_STARTUP_DEF
) (
    input wire logic REF_CLK, // System clock
    input wire logic NRST, // Sync reset
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB write
    input wire logic [ADDR_W-1:0] PADDR, // APB byte address
    input wire logic [DATA_W-1:0] PWDATA, // APB write data
    output logic [DATA_W-1:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error
    input wire logic [FLAG_N-1:0] SRC_EVENT, // Source event pulses
    input wire logic IRQ_ACK, // Vector taken
    input wire logic IRQ_RETURN, // return_from_interrupt done
    output logic IRQ_REQ, // Request to CPU
    output logic [VEC_W-1:0] IRQ_VECTOR, // Offered vector
    output logic [LEVEL_W-1:0] IRQ_LEVEL, // Offered level
    input wire logic [P0_WIDTH-1:0] P0_IN, // Port 0 pin levels
    input wire logic TIMER_A_RUN, // timer_a_run
    input wire logic TIMER_B_RUN, // timer_b_run
    input wire logic TIMER_C_ENABLE, // timer_c_enable
    input wire logic SERIAL_ENABLE, // Serial port enabled
    input wire logic CONV_ENABLE, // Converter enabled
    input wire logic WDT_OPTION_EN, // Watchdog option
    input wire logic WDT_ALWAYS_ON, // Keeps slow_rc_osc running in STOP
    output logic FAST_OSC_EN, // fast_rc_osc running
    output logic SLOW_OSC_EN, // slow_rc_osc running
    output logic CPU_RUN, // CPU executes
    output logic TIMER_A_CLK_EN, // Timer A clocked
    output logic TIMER_B_CLK_EN, // Timer B clocked
    output logic TIMER_C_CLK_EN, // Timer C clocked
    output logic SERIAL_CLK_EN, // Serial port clocked
    output logic CONV_CLK_EN, // Converter clocked
    output logic WDT_RUN, // Watchdog counting
    output logic IRQ_LOGIC_EN, // Interrupt logic alive
    output logic [1:0] POWER_MODE // Operating mode
);

    localparam int TOTAL_WAKE = WAKE_CYCLES + OSC_STARTUP_CYCLES;
    localparam int CNT_W = $clog2(TOTAL_WAKE + 1);

    if (P0_WIDTH < 1 || WAKE_CYCLES < 1 || OSC_STARTUP_CYCLES < 0) begin : g_check
        $error("bad parameters");
    end

    typedef struct packed {
        logic [FLAG_N-1:0] enable;
        logic [FLAG_N-1:0] flags;
        logic [GROUP_N-1:0] lvl_low;
        logic [GROUP_N-1:0] lvl_high;
        logic idle_bit;
        logic stop_bit;
        logic gp_bit;
        ipwc_mode_t mode;
        logic [CNT_W-1:0] wake_cnt;
        logic [LEVEL_N-1:0] in_svc;
        logic irq_req;
        logic [IDX_W-1:0] req_idx;
        logic [LEVEL_W-1:0] req_lvl;
        logic [VEC_W-1:0] vector;
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
        logic fast_osc;
        logic slow_osc;
        logic cpu_run;
        logic tmr_a;
        logic tmr_b;
        logic tmr_c;
        logic serial;
        logic conv;
        logic wdt;
        logic irq_live;
    } ipwc_state_t;

    ipwc_state_t s_reg;
    ipwc_state_t s_next;

    logic [SRC_N-1:0] pend;
    logic [SRC_N-1:0] pend_en;
    logic arb_valid;
    logic [IDX_W-1:0] arb_idx;
    logic [LEVEL_W-1:0] arb_lvl;
    logic pin_change;
    logic low_power;
    logic any_active;
    logic [LEVEL_W-1:0] act_lvl;
    logic [LEVEL_N-1:0] top_active;

    // Serial pends on tx or rx flag
    always_comb begin
        for (int i = 0; i < SRC_N; i++) begin
            pend[i] = s_reg.flags[i];
        end
        pend[SRC_SERIAL] = s_reg.flags[FLG_SERIAL_TX] | s_reg.flags[FLG_SERIAL_RX];
        pend[SRC_N-1] = s_reg.flags[FLG_TIMER_C];
        pend_en = pend & s_reg.enable[SRC_N-1:0]
            & {SRC_N{s_reg.enable[EN_GLOBAL_BIT]}};
    end

    // Highest level now in service
    always_comb begin
        any_active = |s_reg.in_svc;
        act_lvl = '0;
        top_active = '0;
        for (int l = 0; l < LEVEL_N; l++) begin
            if (s_reg.in_svc[l]) begin
                act_lvl = LEVEL_W'(l);
                top_active = LEVEL_N'(1) << l;
            end
        end
    end

    assign low_power = (s_reg.mode == MODE_IDLE) || (s_reg.mode == MODE_STOP);

    ipwc_arbiter u_arbiter (
        .req(pend_en),
        .lvl_low(s_reg.lvl_low),
        .lvl_high(s_reg.lvl_high),
        .valid(arb_valid),
        .idx(arb_idx),
        .level(arb_lvl)
    );

    // Never disabled by software
    ipwc_pin_change #(
        .WIDTH(P0_WIDTH)
    ) u_pin_change (
        .clk(REF_CLK),
        .nrst(NRST),
        .pins(P0_IN),
        .armed(low_power),
        .change(pin_change)
    );

    always_comb begin
        logic setup;
        logic wr;
        logic ack;
        logic live;
        logic [FLAG_N-1:0] set_mask;
        logic [FLAG_N-1:0] clr_mask;
        setup = PSEL && !PENABLE;
        wr = PSEL && PENABLE && PWRITE && s_reg.pready && !s_reg.pslverr;
        ack = IRQ_ACK && s_reg.irq_req;
        live = (s_reg.mode == MODE_NORMAL) || (s_reg.mode == MODE_IDLE);
        set_mask = '0;
        clr_mask = '0;
        s_next = s_reg;

        // Zero wait states; read data captured at setup
        s_next.pready = setup;
        if (setup) begin
            s_next.pslverr = 1'b0;
            s_next.prdata = '0;
            case (PADDR)
                OFS_ENABLE: s_next.prdata[FLAG_N-1:0] = s_reg.enable;
                OFS_FLAGS: s_next.prdata[FLAG_N-1:0] = s_reg.flags;
                OFS_LEVEL: begin
                    s_next.prdata[GROUP_N-1:0] = s_reg.lvl_low;
                    s_next.prdata[LVL_HIGH_LSB +: GROUP_N] = s_reg.lvl_high;
                end
                OFS_POWER: begin
                    s_next.prdata[PWR_IDLE_BIT] = s_reg.idle_bit;
                    s_next.prdata[PWR_STOP_BIT] = s_reg.stop_bit;
                    s_next.prdata[PWR_GP_BIT] = s_reg.gp_bit;
                end
                OFS_STATUS: begin
                    s_next.prdata[STAT_MODE_LSB +: 2] = s_reg.mode;
                    s_next.prdata[STAT_INSVC_LSB +: LEVEL_N] = s_reg.in_svc;
                    s_next.prdata[STAT_REQ_BIT] = s_reg.irq_req;
                    s_next.prdata[STAT_IDX_LSB +: IDX_W] = s_reg.req_idx;
                end
                default: s_next.pslverr = 1'b1;
            endcase
        end

        if (wr) begin
            case (PADDR)
                OFS_ENABLE: s_next.enable = PWDATA[FLAG_N-1:0];
                OFS_FLAGS: clr_mask = PWDATA[FLAG_N-1:0];
                OFS_LEVEL: begin
                    s_next.lvl_low = PWDATA[GROUP_N-1:0];
                    s_next.lvl_high = PWDATA[LVL_HIGH_LSB +: GROUP_N];
                end
                OFS_POWER: begin
                    s_next.gp_bit = PWDATA[PWR_GP_BIT];
                    if (s_reg.mode == MODE_NORMAL && PWDATA[PWR_STOP_BIT]) begin
                        s_next.stop_bit = 1'b1;
                        s_next.mode = MODE_STOP;
                    end else if (s_reg.mode == MODE_NORMAL && PWDATA[PWR_IDLE_BIT]) begin
                        s_next.idle_bit = 1'b1;
                        s_next.mode = MODE_IDLE;
                    end
                end
                default: ;
            endcase
        end

        // Vectoring clears the taken flag, except the serial flags
        if (ack && s_reg.req_idx != IDX_W'(SRC_SERIAL)) begin
            if (s_reg.req_idx == IDX_W'(SRC_N - 1)) begin
                clr_mask[FLG_TIMER_C] = 1'b1;
            end else begin
                clr_mask[s_reg.req_idx] = 1'b1;
            end
        end

        // Events land even when disabled, not in STOP or WAKE
        if (live) begin
            set_mask = SRC_EVENT;
        end
        s_next.flags = (s_reg.flags & ~clr_mask) | set_mask;

        if (IRQ_RETURN) begin
            s_next.in_svc = s_reg.in_svc & ~top_active;
        end
        if (ack) begin
            s_next.in_svc[s_reg.req_lvl] = 1'b1;
        end

        // Only a strictly higher level is offered
        s_next.irq_req = (s_reg.mode == MODE_NORMAL) && !ack && arb_valid
            && (!any_active || arb_lvl > act_lvl);
        s_next.req_idx = arb_idx;
        s_next.req_lvl = arb_lvl;
        s_next.vector = VECTOR_TABLE[arb_idx];

        case (s_reg.mode)
            MODE_NORMAL: ;
            MODE_IDLE: begin
                if (pin_change || arb_valid) begin
                    s_next.idle_bit = 1'b0;
                    s_next.mode = MODE_NORMAL;
                end
            end
            MODE_STOP: begin
                if (pin_change) begin
                    s_next.wake_cnt = CNT_W'(TOTAL_WAKE - 1);
                    s_next.mode = MODE_WAKE;
                end
            end
            MODE_WAKE: begin
                if (s_reg.wake_cnt == '0) begin
                    s_next.stop_bit = 1'b0;
                    s_next.mode = MODE_NORMAL;
                end else begin
                    s_next.wake_cnt = s_reg.wake_cnt - CNT_W'(1);
                end
            end
            default: s_next.mode = MODE_NORMAL;
        endcase

        // Gating follows the mode being entered
        s_next.fast_osc = (s_next.mode == MODE_NORMAL) || (s_next.mode == MODE_IDLE);
        s_next.slow_osc = s_next.fast_osc || WDT_ALWAYS_ON;
        s_next.cpu_run = (s_next.mode == MODE_NORMAL);
        s_next.tmr_a = s_next.fast_osc && TIMER_A_RUN;
        s_next.tmr_b = s_next.fast_osc && TIMER_B_RUN;
        s_next.tmr_c = s_next.fast_osc && TIMER_C_ENABLE;
        s_next.serial = s_next.fast_osc && SERIAL_ENABLE;
        s_next.conv = s_next.fast_osc && CONV_ENABLE;
        s_next.wdt = WDT_OPTION_EN;
        s_next.irq_live = s_next.fast_osc;
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            s_reg <= '0;
            s_reg.enable <= RST_ENABLE;
            s_reg.flags <= RST_FLAGS;
            s_reg.lvl_low <= RST_LEVEL;
            s_reg.lvl_high <= RST_LEVEL;
            s_reg.vector <= RST_VECTOR;
            s_reg.mode <= MODE_NORMAL;
            s_reg.fast_osc <= 1'b1;
            s_reg.slow_osc <= 1'b1;
            s_reg.cpu_run <= 1'b1;
            s_reg.irq_live <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PRDATA = s_reg.prdata;
    assign PREADY = s_reg.pready;
    assign PSLVERR = s_reg.pslverr;
    assign IRQ_REQ = s_reg.irq_req;
    assign IRQ_VECTOR = s_reg.vector;
    assign IRQ_LEVEL = s_reg.req_lvl;
    assign FAST_OSC_EN = s_reg.fast_osc;
    assign SLOW_OSC_EN = s_reg.slow_osc;
    assign CPU_RUN = s_reg.cpu_run;
    assign TIMER_A_CLK_EN = s_reg.tmr_a;
    assign TIMER_B_CLK_EN = s_reg.tmr_b;
    assign TIMER_C_CLK_EN = s_reg.tmr_c;
    assign SERIAL_CLK_EN = s_reg.serial;
    assign CONV_CLK_EN = s_reg.conv;
    assign WDT_RUN = s_reg.wdt;
    assign IRQ_LOGIC_EN = s_reg.irq_live;
    assign POWER_MODE = s_reg.mode;

endmodule : ipwc_ctrl
`default_nettype wire

// ### src/ipwc_pin_change.sv
`timescale 1ns/1ps
`default_nettype none
module ipwc_pin_change #(
    parameter int WIDTH = 6
) (
    input wire logic clk, // Clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [WIDTH-1:0] pins, // Port pins
    input wire logic armed, // Detection allowed
    output logic change // Pin toggled while armed
);

    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } ipwc_pc_state_t;

    ipwc_pc_state_t s_reg;
    ipwc_pc_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.prev = pins;
    end

    // Either edge on any pin
    assign change = armed && (pins != s_reg.prev);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule : ipwc_pin_change
`default_nettype wire

// ### src/ipwc_pkg.sv
package ipwc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_LEVEL = 8'h08;
    localparam logic [7:0] OFS_POWER = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    localparam int SRC_N = 8;
    localparam int FLAG_N = 9;
    localparam int GROUP_N = 6;
    localparam int LEVEL_W = 2;
    localparam int LEVEL_N = 4;
    localparam int IDX_W = 3;
    localparam int VEC_W = 16;
    localparam int SRC_SERIAL = 6;
    localparam int FLG_SERIAL_TX = 6;
    localparam int FLG_SERIAL_RX = 7;
    localparam int FLG_TIMER_C = 8;

    localparam int EN_GLOBAL_BIT = 8;
    localparam int LVL_HIGH_LSB = 8;
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam int PWR_GP_BIT = 2;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_INSVC_LSB = 4;
    localparam int STAT_REQ_BIT = 8;
    localparam int STAT_IDX_LSB = 12;

    localparam logic [8:0] RST_ENABLE = 9'h000;
    localparam logic [8:0] RST_FLAGS = 9'h000;
    localparam logic [5:0] RST_LEVEL = 6'h00;
    localparam logic [15:0] RST_VECTOR = 16'h0000;

    // Group of each source, natural order
    localparam int GROUP_OF [SRC_N] = '{0, 0, 1, 1, 2, 3, 4, 5};

    localparam logic [15:0] VECTOR_TABLE [SRC_N] = '{
        16'h0003, 16'h0083, 16'h000B, 16'h008B,
        16'h0013, 16'h001B, 16'h0023, 16'h00EB};

    // Stop-exit wait, worked out in picoseconds, rounded up to REF_CLK cycles
    localparam longint FAST_PERIOD_PS = 31250;
    localparam longint SLOW_PERIOD_PS = 62500000;
    localparam longint REF_PERIOD_PS = 25000;
    localparam longint WAKE_FAST_CLKS = 64;
    localparam longint WAKE_SLOW_CLKS = 5;
    localparam longint WAKE_TIME_PS = WAKE_FAST_CLKS * FAST_PERIOD_PS
        + WAKE_SLOW_CLKS * SLOW_PERIOD_PS;
    localparam int WAKE_CYCLES_DEF = int'((WAKE_TIME_PS + REF_PERIOD_PS - 1) / REF_PERIOD_PS);
    localparam int OSC_STARTUP_DEF = 16;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_IDLE,
        MODE_STOP,
        MODE_WAKE
    } ipwc_mode_t;

endpackage : ipwc_pkg
